// File: hdl/cssl_pkg.sv
// Package for the channel service state logic block.
// Assumes a single 200 MHz pclk domain and an APB register slave.
package cssl_pkg;

	localparam int CSSL_CLK_MHZ = 200;

	// Register byte addresses
	localparam logic [7:0] CSSL_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] CSSL_ADDR_STATUS = 8'h04;
	localparam logic [7:0] CSSL_ADDR_OUTS   = 8'h08;

	// Control register fields
	localparam int CSSL_CTRL_SIMCON = 0;
	localparam int CSSL_CTRL_RESET  = 1;

	// Status register fields
	localparam int CSSL_ST_BUSY  = 0;
	localparam int CSSL_ST_OOUT  = 1;
	localparam int CSSL_ST_OIN   = 2;
	localparam int CSSL_ST_TERM  = 3;
	localparam int CSSL_ST_UNUSUAL_END_FLAG  = 4;
	localparam int CSSL_ST_CONN  = 5;

	// Data line positions
	localparam int CSSL_DL_ZERO  = 0;
	localparam int CSSL_DL_CDONE = 1;
	localparam int CSSL_DL_CHEND = 3;
	localparam int CSSL_DL_UNEND = 4;
	localparam int CSSL_DL_PHALT = 3;

	localparam logic [31:0] CSSL_ZERO32 = 32'h0000_0000;
	localparam logic [7:0]  CSSL_ZERO8  = 8'h00;

	// Function indicators from the channel
	typedef struct packed {
		logic start_io_function;
		logic halt_io_function;
		logic test_io_function;
		logic test_device_function;
		logic acknowledge_irq_function;
	} cssl_func_t;

	// Service-cycle type as coded on the condition lines
	typedef enum logic [1:0] {
		CSSL_CYC_DATA_IN,
		CSSL_CYC_ORDER_IN,
		CSSL_CYC_ORDER_OUT
	} cssl_cycle_t;

	// Flag set kept by the state logic
	typedef struct packed {
		logic busy;
		logic order_out;
		logic order_in;
		logic terminal_order;
		logic unusual_end;
	} cssl_flags_t;

endpackage

// File: hdl/cssl_fall_detect.sv
// Falling-edge detector for strobes sampled in the pclk domain.
// Assumes the strobe is already synchronous to pclk.
`timescale 1ns/100ps
module cssl_fall_detect
	import cssl_pkg::*;
#(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	// Strobes
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] fall_pulse
);

	logic [WIDTH-1:0] level_q;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					level_q[g] <= 1'b0;
				else if (clk_en)
					level_q[g] <= level_in[g];
			end
			// Combinational edge against the registered level: the pulse lasts one enabled cycle
			assign fall_pulse[g] = clk_en & level_q[g] & ~level_in[g];
		end
	endgenerate

endmodule

// File: hdl/cssl_state_logic.sv
// State logic of a character-oriented comms controller channel end.
// Assumes all channel and subcontroller inputs are synchronous to pclk;
// software reaches control and status over APB.
//
// Behaviour
// - Busy flag: set busy, clear ready
// - Busy only on addressed start, idle, no irq
// - Busy armed by start, set at strobe fall
// - Addressed halt while unconnected returns ready
// - Unusual end plus end service returns ready
// - Busy reported; routes bit eight onto line 0
// - Start success drives io condition line
// - Halt io condition equals not busy
// - Order-out sets together with busy
// - Count done during order-out is ignored; processor halt is not
// - Order-out clears at terminal strobe with end service
// - Order-out connected drives both condition lines
// - End data during connected order-out/order-in
// - Order-in sets on terminal order with halt/done
// - Order-in status byte carries unusual end only
// - Order-in connected drives data/order line only
// - Order-in clears at following terminal strobe
// - Terminal-order flag marks terminal transfer
// - Terminal flag sets on end data, clears on end service
// - Five flags; make end data and conditions
// - Connected, no order: both lines false
// - Unusual end: set on order-in, cleared by start/halt/reset
`timescale 1ns/100ps
module cssl_state_logic
	import cssl_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Channel function side
	input  wire cssl_func_t  func,
	input  wire logic        function_strobe_received,
	input  wire logic        function_strobe_internal,
	input  wire logic        device_addressed,
	input  wire logic        internal_irq_pending,
	// Service side
	input  wire logic        service_connect_flag,
	input  wire logic        request_strobe_internal,
	input  wire logic        end_service_received,
	input  wire logic        end_data_received,
	input  wire logic        subcontroller_input_enable,
	input  wire logic        count_done_line,
	input  wire logic        processor_halt_line,
	input  wire logic        received_bit_eight,
	input  wire logic        external_reset,
	// Outputs to the subcontroller
	output logic             io_condition_line,
	output logic             data_order_condition_line,
	output logic             end_data_drive,
	output logic [7:0]       data_lines,
	output logic             busy_status,
	output logic             unusual_end_status,
	output cssl_cycle_t      cycle_type
);

	cssl_flags_t flags;
	logic        simulated_connect_flag;
	logic        connected_any;
	logic        end_service_while_connected;
	logic        busy_arm;
	logic        fs_fall;
	logic        rs_fall;
	logic        fs_rx_fall;
	logic        start_ok_q;
	logic        done_or_halt;
	logic [1:0]  fall_vec;
	logic        apb_access;
	logic        addr_ok;

	// Strobe falls become one-cycle pulses; flags move the next cycle
	cssl_fall_detect #(
		.WIDTH(2)
	) u_fall (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.level_in  ({request_strobe_internal, function_strobe_internal}),
		.fall_pulse(fall_vec)
	);

	assign fs_fall = fall_vec[0];
	assign rs_fall = fall_vec[1];

	// Channel strobe as received, needed by the start-side unusual-end clear
	logic fs_rx_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fs_rx_q <= 1'b0;
		else if (clk_en)
			fs_rx_q <= function_strobe_received;
	end
	assign fs_rx_fall = clk_en & fs_rx_q & ~function_strobe_received;

	// Start conditions captured while the received strobe stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_ok_q <= 1'b0;
		else if (clk_en)
			start_ok_q <= func.start_io_function & ~internal_irq_pending
				& ~flags.busy & device_addressed;
	end

	assign connected_any = service_connect_flag | simulated_connect_flag;
	assign end_service_while_connected =
		end_service_received & service_connect_flag;
	assign busy_arm = func.start_io_function & ~internal_irq_pending
		& ~service_connect_flag;

	// Count done only counts outside order-out; processor halt always does
	assign done_or_halt = (count_done_line & ~flags.order_out)
		| processor_halt_line;

	// Busy flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags.busy <= 1'b0;
		end else if (clk_en) begin
			if (fs_fall && device_addressed && func.halt_io_function
			    && !service_connect_flag)
				flags.busy <= 1'b0;
			else if (rs_fall && service_connect_flag && flags.order_in
			         && end_service_while_connected && flags.unusual_end)
				flags.busy <= 1'b0;
			else if (fs_fall && device_addressed && busy_arm)
				flags.busy <= 1'b1;
		end
	end

	// Order-out: first service cycle after a start; its count done is ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags.order_out <= 1'b0;
		end else if (clk_en) begin
			if (rs_fall && flags.order_out && end_service_while_connected)
				flags.order_out <= 1'b0;
			else if (fs_fall && device_addressed && busy_arm && !flags.busy)
				flags.order_out <= 1'b1;
		end
	end

	// Order-in: entered from a terminal order carrying done or halt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags.order_in <= 1'b0;
		end else if (clk_en) begin
			if (rs_fall && flags.order_in && end_service_while_connected)
				flags.order_in <= 1'b0;
			else if (rs_fall && flags.terminal_order && !flags.order_in
			         && done_or_halt)
				flags.order_in <= 1'b1;
		end
	end

	// Terminal order; the channel keeps its end-service ordering
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags.terminal_order <= 1'b0;
		end else if (clk_en && rs_fall) begin
			if (end_service_while_connected)
				flags.terminal_order <= 1'b0;
			else if (subcontroller_input_enable && end_data_received)
				flags.terminal_order <= 1'b1;
		end
	end

	// Unusual end; the external reset wins, but only on an edge where clk_en is high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags.unusual_end <= 1'b0;
		end else if (clk_en) begin
			if (external_reset)
				flags.unusual_end <= 1'b0;
			else if (rs_fall && flags.terminal_order && !flags.unusual_end
			         && !flags.order_in
			         && done_or_halt)
				flags.unusual_end <= 1'b1;
			else if ((fs_fall && device_addressed && func.halt_io_function)
			         || (fs_rx_fall && start_ok_q))
				flags.unusual_end <= 1'b0;
		end
	end

	// Condition lines and cycle coding
	always_comb begin
		io_condition_line         = 1'b0;
		data_order_condition_line = 1'b0;
		cycle_type                = CSSL_CYC_DATA_IN;
		if (connected_any && flags.order_out) begin
			io_condition_line         = 1'b1;
			data_order_condition_line = 1'b1;
			cycle_type                = CSSL_CYC_ORDER_OUT;
		end else if (connected_any && flags.order_in) begin
			data_order_condition_line = 1'b1;
			cycle_type                = CSSL_CYC_ORDER_IN;
		end
		if (function_strobe_received && device_addressed) begin
			if (func.start_io_function && !internal_irq_pending
			    && !flags.busy)
				io_condition_line = 1'b1;
			if (func.halt_io_function && !flags.busy)
				io_condition_line = 1'b1;
			if (func.test_io_function && !internal_irq_pending
			    && !flags.busy)
				io_condition_line = 1'b1;
			if (func.test_device_function)
				io_condition_line = 1'b1;
			data_order_condition_line = 1'b1;
		end
		if (function_strobe_received && func.acknowledge_irq_function) begin
			io_condition_line         = 1'b1;
			data_order_condition_line = 1'b1;
		end
	end

	assign end_data_drive = connected_any
		& (flags.order_out | flags.order_in);

	// Data lines come from a register to keep glitches off the channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_lines <= CSSL_ZERO8;
		end else if (clk_en) begin
			data_lines <= CSSL_ZERO8;
			if (flags.busy)
				data_lines[CSSL_DL_ZERO] <= received_bit_eight;
			if (flags.order_in && connected_any) begin
				data_lines[CSSL_DL_CHEND] <= flags.unusual_end;
				data_lines[CSSL_DL_UNEND] <= flags.unusual_end;
			end
		end
	end

	assign busy_status        = flags.busy;
	assign unusual_end_status = flags.unusual_end;

	// APB: zero-wait slave, unmapped addresses answer with an error
	assign apb_access = psel & penable;
	assign addr_ok    = (paddr == CSSL_ADDR_CTRL)
		| (paddr == CSSL_ADDR_STATUS) | (paddr == CSSL_ADDR_OUTS);
	assign pready     = 1'b1;
	assign pslverr    = apb_access & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			simulated_connect_flag <= 1'b0;
		else if (clk_en && apb_access && pwrite
		         && paddr == CSSL_ADDR_CTRL)
			simulated_connect_flag <= pwdata[CSSL_CTRL_SIMCON];
	end

	always_comb begin
		prdata = CSSL_ZERO32;
		if (apb_access && !pwrite) begin
			unique case (paddr)
				CSSL_ADDR_CTRL:
					prdata[CSSL_CTRL_SIMCON] = simulated_connect_flag;
				CSSL_ADDR_STATUS: begin
					prdata[CSSL_ST_BUSY] = flags.busy;
					prdata[CSSL_ST_OOUT] = flags.order_out;
					prdata[CSSL_ST_OIN]  = flags.order_in;
					prdata[CSSL_ST_TERM] = flags.terminal_order;
					prdata[CSSL_ST_UNUSUAL_END_FLAG] = flags.unusual_end;
					prdata[CSSL_ST_CONN] = connected_any;
				end
				CSSL_ADDR_OUTS:
					prdata[7:0] = data_lines;
				default:
					prdata = CSSL_ZERO32;
			endcase
		end
	end

endmodule

// File: sim/cssl_sva.sv
// Checker for the state flags, condition lines and status byte.
// Assumes clk_en stays high while flags are expected to move.
`timescale 1ns/100ps
module cssl_sva
	import cssl_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	// Inputs watched
	input wire cssl_func_t  func,
	input wire logic        function_strobe_received,
	input wire logic        function_strobe_internal,
	input wire logic        device_addressed,
	input wire logic        internal_irq_pending,
	input wire logic        service_connect_flag,
	input wire logic        external_reset,
	input wire logic        received_bit_eight,
	// Outputs watched
	input wire logic        io_condition_line,
	input wire logic        data_order_condition_line,
	input wire logic        end_data_drive,
	input wire logic [7:0]  data_lines,
	input wire logic        busy_status,
	input wire logic        unusual_end_status,
	input wire cssl_cycle_t cycle_type
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire fsa = function_strobe_received && device_addressed;
	chk_start_code: assert property (
		fsa && func == 5'h10 && cycle_type == CSSL_CYC_DATA_IN
		|-> io_condition_line == (!internal_irq_pending && !busy_status))
		else $error("start condition code wrong");
	chk_halt_code: assert property (
		fsa && func == 5'h08 && cycle_type == CSSL_CYC_DATA_IN
		|-> io_condition_line == !busy_status)
		else $error("halt condition code wrong");
	chk_busy_set: assert property (
		$fell(function_strobe_internal) && device_addressed && clk_en
		&& func == 5'h10 && !internal_irq_pending && !service_connect_flag
		|-> ##2 busy_status)
		else $error("busy did not set after start");
	chk_halt_ready: assert property (
		$fell(function_strobe_internal) && device_addressed && clk_en
		&& func == 5'h08 && !service_connect_flag |-> ##2 !busy_status)
		else $error("busy did not clear after halt");
	chk_oout_code: assert property (
		cycle_type == CSSL_CYC_ORDER_OUT |-> io_condition_line
		&& data_order_condition_line && end_data_drive)
		else $error("order-out code wrong");
	chk_oin_code: assert property (
		cycle_type == CSSL_CYC_ORDER_IN && !function_strobe_received
		|-> !io_condition_line && data_order_condition_line && end_data_drive)
		else $error("order-in code wrong");
	chk_data_code: assert property (
		cycle_type == CSSL_CYC_DATA_IN && !function_strobe_received
		|-> !io_condition_line && !data_order_condition_line)
		else $error("data-in code wrong");
	chk_oin_byte: assert property (
		$past(cycle_type) == CSSL_CYC_ORDER_IN && $past(clk_en)
		|-> data_lines[CSSL_DL_UNEND] == $past(unusual_end_status)
		&& data_lines[7:5] == 3'h0)
		else $error("order-in status byte wrong");
	chk_bit_eight: assert property (
		$past(busy_status) && $past(clk_en)
		|-> data_lines[CSSL_DL_ZERO] == $past(received_bit_eight))
		else $error("bit eight not on line zero");
	chk_ext_clear: assert property (
		external_reset && clk_en |-> ##[1:3] !unusual_end_status)
		else $error("unusual end not cleared");
	chk_reset_idle: assert property (
		$rose(presetn) |-> !busy_status && !unusual_end_status)
		else $error("flags not clear after reset");
	cover property (cycle_type == CSSL_CYC_ORDER_IN);
	cover property ($rose(busy_status));
	cover property ($fell(busy_status) && unusual_end_status);
endmodule

bind cssl_state_logic cssl_sva u_sva (.*);

// File: sim/cssl_chan.sv
// Channel processor model: issues functions and request strobes.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
module cssl_chan
	import cssl_pkg::*;
(
	// Clock
	input  wire logic  pclk,
	// Function side
	output cssl_func_t func,
	output logic       fstb,
	output logic       fsi,
	output logic       dsel,
	// Service side
	output logic       rs,
	output logic       es,
	output logic       ed,
	output logic [1:0] ord
);
	initial begin
		{func, fstb, fsi, dsel, rs, es, ed, ord} = '0;
	end
	task fn_on(input cssl_func_t f);
		@(posedge pclk);
		func <= f;
		dsel <= 1'h1;
		@(posedge pclk);
		fstb <= 1'h1;
		fsi  <= 1'h1;
		@(posedge pclk);
	endtask
	// Function held two more cycles so the capture sees it
	task fn_off();
		@(posedge pclk);
		fstb <= 1'h0;
		fsi  <= 1'h0;
		repeat (2) @(posedge pclk);
		func <= '0;
		dsel <= 1'h0;
	endtask
	// End service only rides on the terminal strobe
	task strobe(input logic e_s, input logic e_d, input logic [1:0] o);
		@(posedge pclk);
		rs  <= 1'h1;
		es  <= e_s;
		ed  <= e_d;
		ord <= o;
		@(posedge pclk);
		rs <= 1'h0;
		repeat (3) @(posedge pclk);
		es  <= 1'h0;
		ed  <= 1'h0;
		ord <= ~o;
	endtask
endmodule

// File: sim/tb_top.sv
// Bench for the state logic: functions, service cycles and APB.
// Assumes the channel model drives the function, strobe and order inputs; the bench drives irq pending and the rest.
`timescale 1ns/100ps
module tb_top
	import cssl_pkg::*;
;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, err;
	logic [7:0]  paddr, data_lines;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, internal_irq_pending, external_reset;
	logic        service_connect_flag, received_bit_eight;
	logic        subcontroller_input_enable, device_addressed;
	logic        function_strobe_received, function_strobe_internal;
	logic        request_strobe_internal, end_service_received;
	logic        end_data_received, count_done_line, processor_halt_line;
	logic        io_condition_line, data_order_condition_line;
	logic        end_data_drive, busy_status, unusual_end_status;
	cssl_func_t  func;
	cssl_cycle_t cycle_type;
	int          error_cnt, checks_done, cyc;
	localparam cssl_func_t FN [9] = '{5'h10, 5'h10, 5'h04, 5'h10, 5'h08,
		5'h08, 5'h02, 5'h01, 5'h04};

	cssl_state_logic uut (.*);
	cssl_chan ch (
		.pclk (pclk),
		.func (func),
		.fstb (function_strobe_received),
		.fsi  (function_strobe_internal),
		.dsel (device_addressed),
		.rs   (request_strobe_internal),
		.es   (end_service_received),
		.ed   (end_data_received),
		.ord  ({processor_halt_line, count_done_line})
	);

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task st(input logic [4:0] e);
		apb(1'h0, CSSL_ADDR_STATUS, 32'h0);
		chk("status", rd[4:0], e);
	endtask
	task t_reset();
		st(5'h00);
		chk("lines", data_lines, 8'h00);
		apb(1'h1, CSSL_ADDR_CTRL, 32'h1);
		apb(1'h0, CSSL_ADDR_CTRL, 32'h0);
		chk("ctrl", rd[0], 1'h1);
		apb(1'h0, 8'h0C, 32'h0);
		chk("slverr", err, 1'h1);
		apb(1'h1, CSSL_ADDR_CTRL, 32'h0);
		$display("test reset done");
	endtask
	// Start with irq, start, test busy, start busy, halt busy, halt ready,
	// device test, irq acknowledge, test ready
	task t_func();
		for (int i = 0; i < 9; i++) begin
			@(posedge pclk);
			internal_irq_pending <= (i == 0);
			ch.fn_on(FN[i]);
			@(negedge pclk);
			chk("io", io_condition_line, i == 1 || i >= 5);
			chk("dor", data_order_condition_line, 1'h1);
			ch.fn_off();
			@(negedge pclk);
			chk("busy", busy_status, i >= 1 && i <= 3);
		end
		$display("test functions done");
	endtask
	task t_svc(input logic [1:0] o);
		ch.fn_on(5'h10);
		ch.fn_off();
		@(negedge pclk);
		chk("unusual_end_flag start", unusual_end_status, 1'h0);
		st(5'h03);
		apb(1'h1, CSSL_ADDR_CTRL, 32'h1);
		@(negedge pclk);
		chk("sim oout", cycle_type, CSSL_CYC_ORDER_OUT);
		apb(1'h1, CSSL_ADDR_CTRL, 32'h0);
		@(posedge pclk);
		service_connect_flag <= 1'h1;
		received_bit_eight <= 1'h1;
		repeat (2) @(negedge pclk);
		chk("oout", cycle_type, CSSL_CYC_ORDER_OUT);
		chk("edd oout", end_data_drive, 1'h1);
		chk("dor oout", data_order_condition_line, 1'h1);
		chk("bit8", data_lines[0], 1'h1);
		ch.strobe(1'h0, 1'h1, 2'h3);
		st(5'h0B);
		// Count done in order-out must not open an order-in cycle
		ch.strobe(1'h1, 1'h0, 2'h1);
		@(negedge pclk);
		chk("data in", cycle_type, CSSL_CYC_DATA_IN);
		chk("edd data", end_data_drive, 1'h0);
		chk("io data", io_condition_line, 1'h0);
		ch.strobe(1'h0, 1'h1, 2'h0);
		ch.strobe(1'h1, 1'h0, o);
		@(negedge pclk);
		chk("oin", cycle_type, CSSL_CYC_ORDER_IN);
		chk("io oin", io_condition_line, 1'h0);
		chk("edd oin", end_data_drive, 1'h1);
		chk("byte", data_lines, 8'h19);
		ch.strobe(1'h0, 1'h1, 2'h0);
		ch.strobe(1'h1, 1'h0, 2'h0);
		st(5'h10);
		@(posedge pclk);
		service_connect_flag <= 1'h0;
		received_bit_eight <= 1'h0;
		$display("test service done");
	endtask
	task t_ext();
		// A low clock enable must hold the flag through the pulse
		@(posedge pclk);
		clk_en <= 1'h0;
		external_reset <= 1'h1;
		@(posedge pclk);
		external_reset <= 1'h0;
		@(posedge pclk);
		clk_en <= 1'h1;
		@(negedge pclk);
		chk("unusual_end_flag frozen", unusual_end_status, 1'h1);
		@(posedge pclk);
		external_reset <= 1'h1;
		@(posedge pclk);
		external_reset <= 1'h0;
		repeat (3) @(negedge pclk);
		chk("unusual_end_flag ext", unusual_end_status, 1'h0);
		$display("test external reset done");
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{internal_irq_pending, service_connect_flag} = '0;
		{received_bit_eight, external_reset} = '0;
		clk_en = 1'h1;
		subcontroller_input_enable = 1'h1;
		{error_cnt, checks_done, cyc} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_func();
		t_svc(2'h1);
		t_svc(2'h2);
		t_ext();
		summarize();
	end
endmodule
